/* File: design/bus_event_detect.sv */
// start, stop and clock-edge detector for the upstream serial bus
`timescale 1ns/1ns
module bus_event_detect (
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output irq_mux_pkg::bus_event_t    event_out
);
	logic scl_q;
	logic sda_q;
	irq_mux_pkg::bus_event_t ev_d;

	always_comb begin
		ev_d.start = scl_in && scl_q && sda_q && !sda_in;
		ev_d.stop  = scl_in && scl_q && !sda_q && sda_in;
		ev_d.rise  = scl_in && !scl_q;
		ev_d.fall  = !scl_in && scl_q;
	end

	// idle bus is high on both lines
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign event_out = ev_d;
endmodule : bus_event_detect

/* File: design/i2c_mux_interrupt_aggregator.sv */
// control byte, channel selection and interrupt aggregation of a four channel bus mux
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "irq_mux_map.svh"
module i2c_mux_interrupt_aggregator #(
	parameter int NUM_CH = `NUM_CHANNELS
) (
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_oe_out,
	output logic                   sda_out,
	input  wire logic              addr_strap_low_in,
	input  wire logic              addr_strap_mid_in,
	input  wire logic              addr_strap_hi_in,
	input  wire logic [NUM_CH-1:0] irq_in_ch_b_in,
	output logic                   irq_comb_oe_out,
	output logic                   irq_comb_b_out,
	output logic [NUM_CH-1:0]      channel_active_out
);
	irq_mux_pkg::bus_event_t   ev;
	irq_mux_pkg::bus_state_t   state_q;
	irq_mux_pkg::bus_state_t   state_d;
	irq_mux_pkg::ctrl_byte_t   ctrl_q;
	logic [7:0]                shift_q;
	logic [2:0]                bit_q;
	logic [7:0]                rd_q;
	logic [7:0]                rd_load;
	logic                      pending_q;
	logic                      sda_oe_q;
	logic                      irq_oe_q;
	logic [NUM_CH-1:0]         active_q;
	logic [NUM_CH-1:0]         irq_act;
	logic [NUM_CH-1:0]         sel_dec;
	logic [7:0]                shift_d;
	logic                      byte_done;
	logic                      addr_hit;
	logic [6:0]                my_addr;

	bus_event_detect u_events (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.event_out (ev)
	);

	//////////////////////////////////////////////////////////////////////////
	// decode
	assign irq_act   = ~irq_in_ch_b_in;
	assign my_addr   = {`ADDR_FIXED_HI, addr_strap_mid_in, addr_strap_low_in};
	assign shift_d   = {shift_q[6:0], sda_in};
	assign byte_done = ev.rise && (bit_q == 3'h7);
	assign addr_hit  = (shift_d[7:1] == my_addr);
	// read byte: live interrupt levels over the stored selection bits
	assign rd_load   = {irq_act, ctrl_q.spare_bit_three, ctrl_q.channel_enable_bit,
		ctrl_q.channel_index_hi, ctrl_q.channel_index_lo};
	// strap a2 kept for board compatibility; only two straps shift the address here
	logic unused_strap;
	assign unused_strap = addr_strap_hi_in;

	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_sel
			assign sel_dec[i] = ctrl_q.channel_enable_bit &&
				({ctrl_q.channel_index_hi, ctrl_q.channel_index_lo} == 2'(i));
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// bus state machine, moves on scl edges and on start and stop
	always_comb begin
		state_d = state_q;
		if (ev.start) begin
			state_d = irq_mux_pkg::ST_ADDR;
		end else if (ev.stop) begin
			state_d = irq_mux_pkg::ST_IDLE;
		end else begin
			case (state_q)
				irq_mux_pkg::ST_ADDR: begin
					if (byte_done)
						state_d = addr_hit ? irq_mux_pkg::ST_AACK : irq_mux_pkg::ST_SKIP;
				end
				irq_mux_pkg::ST_AACK: begin
					// leave on the fall that ends our own ack; bit_q has moved on by then
					if (ev.fall && sda_oe_q)
						state_d = shift_q[0] ? irq_mux_pkg::ST_RDAT : irq_mux_pkg::ST_WDAT;
				end
				irq_mux_pkg::ST_WDAT: begin
					if (byte_done)
						state_d = irq_mux_pkg::ST_WACK;
				end
				irq_mux_pkg::ST_WACK: begin
					if (ev.fall && sda_oe_q)
						state_d = irq_mux_pkg::ST_WDAT;
				end
				irq_mux_pkg::ST_RDAT: begin
					if (byte_done)
						state_d = irq_mux_pkg::ST_RACK;
				end
				irq_mux_pkg::ST_RACK: begin
					if (ev.rise)
						state_d = sda_in ? irq_mux_pkg::ST_SKIP : irq_mux_pkg::ST_RDAT;
				end
				irq_mux_pkg::ST_IDLE: state_d = irq_mux_pkg::ST_IDLE;
				irq_mux_pkg::ST_SKIP: state_d = irq_mux_pkg::ST_SKIP;
				default: state_d = irq_mux_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= irq_mux_pkg::ST_IDLE;
			bit_q   <= 3'h0;
			shift_q <= 8'h00;
		end else begin
			state_q <= state_d;
			if (ev.start || (state_q != state_d))
				bit_q <= 3'h0;
			else if (ev.rise)
				bit_q <= bit_q + 3'h1;
			// the address ack slot is not shifted in, so shift_q[0] still holds the r/w bit
			if (ev.rise && state_q != irq_mux_pkg::ST_AACK)
				shift_q <= shift_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// control byte; each new byte overwrites the previous one
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_q    <= `CTRL_RESET;
			pending_q <= 1'b0;
		end else if (state_q == irq_mux_pkg::ST_WDAT && byte_done) begin
			ctrl_q.channel_enable_bit <= shift_d[`CTRL_EN_BIT];
			ctrl_q.channel_index_hi   <= shift_d[`CTRL_SEL_MSB];
			ctrl_q.channel_index_lo   <= shift_d[`CTRL_SEL_LSB];
			ctrl_q.spare_bit_three    <= shift_d[`CTRL_SPARE_BIT];
			pending_q                 <= 1'b1;
		end else if (ev.stop) begin
			pending_q <= 1'b0;
		end
	end

	// switches only change at stop so downstream lines connect while idle high
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			active_q <= '0;
		else if (ev.stop && pending_q)
			active_q <= sel_dec;
	end

	//////////////////////////////////////////////////////////////////////////
	// read path: live inputs loaded as the read byte starts
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_q <= 8'h00;
		end else if (state_q != irq_mux_pkg::ST_RDAT && state_d == irq_mux_pkg::ST_RDAT) begin
			rd_q <= rd_load;
		// after a master ack the byte reloads on the rise; its first fall only drives bit 7
		end else if (state_q == irq_mux_pkg::ST_RDAT && ev.fall && bit_q != 3'h0) begin
			rd_q <= {rd_q[6:0], 1'b1};
		end
	end

	// pull low for address and write ack slots and for zero read data bits; released otherwise
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			sda_oe_q <= 1'b0;
		else if (ev.start || ev.stop)
			sda_oe_q <= 1'b0;
		else if (ev.fall) begin
			case (state_d)
				irq_mux_pkg::ST_AACK: sda_oe_q <= (state_q == irq_mux_pkg::ST_AACK) && !sda_oe_q;
				irq_mux_pkg::ST_WACK: sda_oe_q <= !sda_oe_q;
				// rd_q loads on this same edge when entering, so bit 7 comes from rd_load
				irq_mux_pkg::ST_RDAT: begin
					if (state_q != irq_mux_pkg::ST_RDAT)
						sda_oe_q <= !rd_load[7];
					else if (bit_q == 3'h0)
						sda_oe_q <= !rd_q[7];
					else
						sda_oe_q <= !rd_q[6];
				end
				default:              sda_oe_q <= 1'b0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// combined interrupt, unlatched and independent of selection
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			irq_oe_q <= 1'b0;
		else
			irq_oe_q <= |irq_act;
	end

	assign sda_oe_out         = sda_oe_q;
	assign sda_out            = 1'b0;
	assign irq_comb_oe_out    = irq_oe_q;
	assign irq_comb_b_out     = 1'b0;
	assign channel_active_out = active_q;
endmodule : i2c_mux_interrupt_aggregator

/* File: design/irq_mux_map.svh */
// register layout, reset values and field positions of the channel mux control byte
`ifndef IRQ_MUX_MAP_SVH
`define IRQ_MUX_MAP_SVH

`define CTRL_RESET        8'h00
`define CTRL_SEL_LSB      0
`define CTRL_SEL_MSB      1
`define CTRL_EN_BIT       2
`define CTRL_SPARE_BIT    3
`define CTRL_IRQ_LSB      4
`define CTRL_IRQ_MSB      7
`define ADDR_FIXED_HI     5'h1c
`define NUM_CHANNELS      4

`endif

/* File: design/irq_mux_pkg.sv */
// types shared by the mux control logic
package irq_mux_pkg;

	typedef struct packed {
		logic [3:0] irq_status;
		logic       spare_bit_three;
		logic       channel_enable_bit;
		logic       channel_index_hi;
		logic       channel_index_lo;
	} ctrl_byte_t;

	typedef struct packed {
		logic       start;
		logic       stop;
		logic       rise;
		logic       fall;
	} bus_event_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b011,
		ST_WDAT = 3'b010,
		ST_WACK = 3'b110,
		ST_RDAT = 3'b111,
		ST_RACK = 3'b101,
		ST_SKIP = 3'b100
	} bus_state_t;

endpackage : irq_mux_pkg

/* File: tb/i2c_master_model.sv */
// behavioural upstream bus master
`timescale 1ns/1ns
module i2c_master_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_pull_out
);
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// third of a bit, long enough for the two-sample edge detector
	task automatic hp();
		repeat (8) @(negedge clk_in);
	endtask : hp
	task automatic start();
		sda_pull_out = 1'b0;
		hp();
		scl_out = 1'b1;
		hp();
		sda_pull_out = 1'b1;
		hp();
		scl_out = 1'b0;
		hp();
	endtask : start
	task automatic stop();
		sda_pull_out = 1'b1;
		hp();
		scl_out = 1'b1;
		hp();
		sda_pull_out = 1'b0;
		hp();
	endtask : stop
	task automatic bitx(input logic b, output logic s);
		sda_pull_out = !b;
		hp();
		scl_out = 1'b1;
		hp();
		s = sda_in;
		scl_out = 1'b0;
		hp();
	endtask : bitx
	task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(m_ack, ack);
	endtask : xfer
endmodule : i2c_master_model

/* File: tb/i2c_mux_interrupt_aggregator_tb.sv */
// self-checking bench for channel selection and interrupt status
`timescale 1ns/1ns
`include "irq_mux_map.svh"
module i2c_mux_interrupt_aggregator_tb;
	logic       clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic [3:0] irq_b = 4'hf;
	logic [1:0] strap = 2'b00;
	logic       scl, pull, sda_oe, comb_oe, a;
	logic [3:0] ch;
	logic [7:0] r;
	int         n_fail = 0;
	int         comparisons = 0;
	// released line floats high through the pull-up
	wire        sda = !(pull | sda_oe);
	always #5 clk_in = ~clk_in;
	i2c_master_model mst_u (.clk_in, .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
	i2c_mux_interrupt_aggregator dut_u (.clk_in, .rst_b_in, .scl_in(scl), .sda_in(sda), .sda_oe_out(sda_oe),
		.sda_out(), .addr_strap_low_in(strap[0]), .addr_strap_mid_in(strap[1]), .addr_strap_hi_in(1'b0),
		.irq_in_ch_b_in(irq_b), .irq_comb_oe_out(comb_oe), .irq_comb_b_out(), .channel_active_out(ch));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d0, input logic [7:0] d1, input bit two);
		mst_u.start();
		mst_u.xfer({`ADDR_FIXED_HI, strap, 1'b0}, 1'b1, r, a);
		chk({7'h0, a}, 8'h00);
		mst_u.xfer(d0, 1'b1, r, a);
		if (two) mst_u.xfer(d1, 1'b1, r, a);
	endtask : wr
	task automatic rd(input logic [7:0] exp);
		mst_u.start();
		mst_u.xfer({`ADDR_FIXED_HI, strap, 1'b1}, 1'b1, r, a);
		mst_u.xfer(8'hff, 1'b1, r, a);
		mst_u.stop();
		chk(r, exp);
	endtask : rd
	task automatic t_sel();
		logic [7:0] c [5] = '{8'h03, 8'h04, 8'h05, 8'h0e, 8'h0f};
		logic [3:0] e [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
		for (int i = 0; i < 5; i++) begin
			wr(c[i], 8'h00, 1'b0);
			chk({4'h0, ch}, {4'h0, i > 0 ? e[i-1] : 4'h0});
			mst_u.stop();
			chk({4'h0, ch}, {4'h0, e[i]});
			rd({4'h0, c[i][3:0]});
		end
		wr(8'h06, 8'h0d, 1'b1);
		mst_u.stop();
		chk({4'h0, ch}, 8'h02);
		rd(8'h0d);
	endtask : t_sel
	task automatic t_irq();
		logic [3:0] p [5] = '{4'he, 4'h5, 4'ha, 4'h0, 4'hf};
		foreach (p[i]) begin
			irq_b = p[i];
			repeat (3) @(negedge clk_in);
			chk({7'h0, comb_oe}, {7'h0, p[i] != 4'hf});
			rd({~p[i], 4'hd});
		end
		irq_b = 4'hb;
		wr(8'h06, 8'h00, 1'b0);
		mst_u.stop();
		chk({4'h0, ch}, 8'h04);
		// the status bit follows the live line: set while channel 2 pulls low, clear once it releases
		rd(8'h46);
		irq_b = 4'hf;
		repeat (3) @(negedge clk_in);
		chk({7'h0, comb_oe}, 8'h00);
		rd(8'h06);
		irq_b = 4'hb;
	endtask : t_irq
	task automatic t_addr();
		for (int i = 0; i < 4; i++) begin
			strap = 2'(i);
			mst_u.start();
			mst_u.xfer({`ADDR_FIXED_HI, ~strap, 1'b1}, 1'b1, r, a);
			mst_u.stop();
			chk({7'h0, a}, 8'h01);
			rd(8'h46);
		end
	endtask : t_addr
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (100000) @(posedge clk_in);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (5) @(negedge clk_in);
		rst_b_in = 1'b1;
		chk({4'h0, ch}, 8'h00);
		rd(8'h00);
		t_sel();
		$display("selection test done");
		t_irq();
		$display("interrupt test done");
		t_addr();
		$display("address test done");
		rst_b_in = 1'b0;
		repeat (5) @(negedge clk_in);
		rst_b_in = 1'b1;
		chk({4'h0, ch}, 8'h00);
		rd(8'h40);
		$display("reset test done");
		wrap_up();
	end
endmodule : i2c_mux_interrupt_aggregator_tb

/* File: tb/irq_mux_chk.sv */
// port assertions for the mux aggregator
`timescale 1ns/1ns
module irq_mux_chk #(
	parameter int NUM_CH = 4
) (
	input wire logic              clk_in,
	input wire logic              rst_b_in,
	input wire logic              scl_in,
	input wire logic              sda_in,
	input wire logic              sda_oe_out,
	input wire logic              sda_out,
	input wire logic [NUM_CH-1:0] irq_in_ch_b_in,
	input wire logic              irq_comb_oe_out,
	input wire logic              irq_comb_b_out,
	input wire logic [NUM_CH-1:0] channel_active_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_comb; $past(rst_b_in) |-> irq_comb_oe_out == $past(|(~irq_in_ch_b_in)); endproperty
	a_comb: assert property (p_comb) else $error("combined irq wrong");
	property p_idle; (&irq_in_ch_b_in)[*2] |-> !irq_comb_oe_out; endproperty
	a_idle: assert property (p_idle) else $error("irq held");
	property p_any; (!(&irq_in_ch_b_in))[*2] |-> irq_comb_oe_out; endproperty
	a_any: assert property (p_any) else $error("irq missed");
	property p_od; irq_comb_b_out == 1'b0 && sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("not open drain");
	property p_sel; $onehot0(channel_active_out); endproperty
	a_sel: assert property (p_sel) else $error("two channels");
	property p_stop; $past(rst_b_in) && $changed(channel_active_out) |-> scl_in && sda_in; endproperty
	a_stop: assert property (p_stop) else $error("switch mid transfer");
	property p_init; $rose(rst_b_in) |-> channel_active_out == '0 && !sda_oe_out && !irq_comb_oe_out; endproperty
	a_init: assert property (p_init) else $error("bad reset state");
	property p_sda; $past(rst_b_in) && $changed(sda_oe_out) |-> !scl_in; endproperty
	a_sda: assert property (p_sda) else $error("data moved, clock high");
endmodule : irq_mux_chk

bind i2c_mux_interrupt_aggregator irq_mux_chk #(.NUM_CH(NUM_CH)) chk_u (.clk_in, .rst_b_in, .scl_in, .sda_in,
	.sda_oe_out, .sda_out, .irq_in_ch_b_in, .irq_comb_oe_out, .irq_comb_b_out, .channel_active_out);
